/* File: verilog/mcuic_pkg.sv */
// mcuic_pkg: register map, field layout, reset values and types of the interrupt controller
// assumes a 32-bit ahb-lite bus with one register per aligned word
package mcuic_pkg;
   // printed offsets are not all multiples of four: they are register indices
   localparam logic [7:0] IDX_EDGE = 8'hbf;
   localparam logic [7:0] IDX_FLAGS = 8'hc8;
   localparam logic [7:0] IDX_ENABLES = 8'hc9;
   localparam logic [7:0] IDX_STACK = 8'hdf;
   localparam logic [7:0] IDX_CTX_ACC = 8'he0;
   localparam logic [7:0] IDX_CTX_PFL = 8'he1;
   localparam logic [7:0] IDX_CPU_CTL = 8'he2;
   localparam logic [7:0] IDX_PC = 8'he3;
   localparam int BIT_EXT = 0;
   localparam int BIT_MSP = 1;
   localparam int BIT_SIO = 3;
   localparam int BIT_T0 = 4;
   localparam int BIT_TC1 = 6;
   localparam int BIT_CMP = 7;
   localparam logic [7:0] SRC_MASK = 8'hdb;
   localparam int GIE_BIT = 7;
   localparam logic [2:0] STACK_RESET = 3'h7;
   localparam int EDGE_LSB = 3;
   localparam logic [1:0] EDGE_RESET = 2'h2;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam logic [7:0] PFL_KEEP_MASK = 8'hc0;
   localparam logic [15:0] IRQ_VECTOR = 16'h0008;
   localparam int CTL_PUSH = 0;
   localparam int CTL_POP = 1;
   localparam int CTL_RETURN_FROM_IRQ_INSTR = 2;
   localparam int CTL_BOUNDARY = 3;
   typedef enum logic [1:0]
   {
      MCUIC_RUN = 2'b00,
      MCUIC_SERVICE = 2'b01,
      MCUIC_SLEEP = 2'b10
   } mcuic_state_e;
   typedef struct packed
   {
      logic [7:0] acc;
      logic [7:0] pflags;
   } mcuic_ctx_s;
endpackage : mcuic_pkg

/* File: verilog/mcuic_edge_det.sv */
// mcuic_edge_det: edge detector for the external interrupt pin
// assumes the pin is synchronous to hclk
`timescale 1ns/1ps
`default_nettype none
module mcuic_edge_det
   import mcuic_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic pin,
   input wire logic [1:0] sel,
   output logic hit
);
   logic prev_reg;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         prev_reg <= 1'b1;
      else
         prev_reg <= pin;
   end
   // reserved select code detects nothing
   always_comb
   begin
      case (sel)
         EDGE_RISE: hit = pin & ~prev_reg;
         EDGE_FALL: hit = ~pin & prev_reg;
         EDGE_BOTH: hit = pin ^ prev_reg;
         default: hit = 1'b0;
      endcase
   end
endmodule : mcuic_edge_det
`default_nettype wire

/* File: verilog/mcuic_top.sv */
// mcuic_top: interrupt controller of an 8-bit cpu with ahb-lite register access
// assumes the cpu core signals instructions by bus writes to the cpu control register and waits on irq_take
// Notes on behaviour
// - enable register bits 0,1,3,4,6,7 permit each source when written 1.
// - taking an interrupt pushes return stack one level and loads pc with 8.
// - return-from-interrupt leaves service and pops the return stack.
// - each source request sets its flag bit at the enable bit position.
// - flags stay set until software clears them by writing the flag register.
// - nothing vectors unless global enable, stack register bit 7, is 1; resets 0.
// - save/restore uses one buffer level; a second save overwrites the first.
// - timeout and power-down status bits are neither saved nor restored.
// - configured external edge sets its flag regardless of its enable.
// - enabled external edge redirects pc to vector 8.
// - matching edge during power-down is latched and serviced first on wake.
// - edge field bits 4:3: 01 rise, 10 fall, 11 both, 00 reserved; reset 10.
// - six sources: two timers, master serial, serial io, comparator, external pin.
// - entering service clears global enable; return sets it again.
// - timer overflow sets its flag regardless of enable; vector needs enable too.
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module mcuic_top
   import mcuic_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ext_pin,
   input wire logic msp_req,
   input wire logic sio_req,
   input wire logic t0_ovf,
   input wire logic tc1_ovf,
   input wire logic cmp_req,
   input wire logic powerdown,
   input wire logic [7:0] cpu_acc,
   input wire logic [7:0] cpu_pflags,
   output logic irq_take,
   output logic [15:0] pc_load,
   output logic wake,
   output logic irq
);
   logic [7:0] flags_reg;
   logic [7:0] enables_reg;
   logic gie_reg;
   logic [2:0] stack_reg;
   logic [1:0] edge_reg;
   mcuic_ctx_s ctx_reg;
   mcuic_ctx_s restore_reg;
   logic [3:0] ctl_reg;
   logic [15:0] pc_reg;
   logic wake_latch_reg;
   mcuic_state_e state_reg;
   logic [7:0] addr_reg;
   logic wr_pend_reg;
   logic rd_ok;
   logic ext_hit;
   logic [7:0] hw_set;
   logic [7:0] sw_clr;
   logic pending;
   logic take;
   logic return_from_irq_instr;

   mcuic_edge_det u_edge
   (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin(ext_pin),
      .sel(edge_reg),
      .hit(ext_hit)
   );

   // ahb-lite slave: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         addr_reg <= 8'h00;
         wr_pend_reg <= 1'b0;
      end
      else
      begin
         wr_pend_reg <= hsel & hready & htrans[1] & hwrite;
         if (hsel & hready & htrans[1])
            addr_reg <= haddr[9:2];
      end
   end
   wire wr_en = wr_pend_reg;
   wire [7:0] wd = hwdata[7:0];

   // source events; external edge counts regardless of its enable
   always_comb
   begin
      hw_set = 8'h00;
      hw_set[BIT_EXT] = ext_hit | wake_latch_reg;
      hw_set[BIT_MSP] = msp_req;
      hw_set[BIT_SIO] = sio_req;
      hw_set[BIT_T0] = t0_ovf;
      hw_set[BIT_TC1] = tc1_ovf;
      hw_set[BIT_CMP] = cmp_req;
   end
   // a write of 0 to a flag clears it, a write of 1 leaves it
   assign sw_clr = (wr_en && addr_reg == IDX_FLAGS) ? (~wd & SRC_MASK) : 8'h00;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flags_reg <= 8'h00;
      else
         flags_reg <= ((flags_reg & ~sw_clr) | hw_set) & SRC_MASK;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         enables_reg <= 8'h00;
      else if (wr_en && addr_reg == IDX_ENABLES)
         enables_reg <= wd & SRC_MASK;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         edge_reg <= EDGE_RESET;
      else if (wr_en && addr_reg == IDX_EDGE)
         edge_reg <= wd[EDGE_LSB +: 2];
   end

   // cpu control pulses written by the core model over the bus
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctl_reg <= 4'h0;
      else if (wr_en && addr_reg == IDX_CPU_CTL)
         ctl_reg <= wd[3:0];
      else
         ctl_reg <= 4'h0;
   end
   assign return_from_irq_instr = ctl_reg[CTL_RETURN_FROM_IRQ_INSTR];

   assign pending = |(flags_reg & enables_reg);
   assign take = pending && gie_reg && ctl_reg[CTL_BOUNDARY] && state_reg != MCUIC_SLEEP;
   assign irq_take = take;
   assign irq = pending & gie_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         gie_reg <= 1'b0;
         stack_reg <= STACK_RESET;
      end
      else if (take)
      begin
         gie_reg <= 1'b0;
         stack_reg <= stack_reg - 3'h1;
      end
      else if (return_from_irq_instr)
      begin
         gie_reg <= 1'b1;
         stack_reg <= stack_reg + 3'h1;
      end
      else if (wr_en && addr_reg == IDX_STACK)
      begin
         gie_reg <= wd[GIE_BIT];
         stack_reg <= wd[2:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         pc_reg <= 16'h0000;
      else if (take)
         pc_reg <= IRQ_VECTOR;
   end
   assign pc_load = pc_reg;

   // single save buffer; status bits are never part of it
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         ctx_reg <= '0;
      else if (ctl_reg[CTL_PUSH])
      begin
         ctx_reg.acc <= cpu_acc;
         ctx_reg.pflags <= cpu_pflags & ~PFL_KEEP_MASK;
      end
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         restore_reg <= '0;
      else if (ctl_reg[CTL_POP])
      begin
         restore_reg.acc <= ctx_reg.acc;
         restore_reg.pflags <= (ctx_reg.pflags & ~PFL_KEEP_MASK) | (cpu_pflags & PFL_KEEP_MASK);
      end
   end

   // sleep: a matching pin edge is latched and becomes the first thing serviced
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         state_reg <= MCUIC_RUN;
      else
      begin
         case (state_reg)
            MCUIC_RUN:
               if (powerdown)
                  state_reg <= MCUIC_SLEEP;
               else if (take)
                  state_reg <= MCUIC_SERVICE;
            MCUIC_SERVICE:
               if (return_from_irq_instr)
                  state_reg <= MCUIC_RUN;
            MCUIC_SLEEP:
               if (ext_hit || !powerdown)
                  state_reg <= MCUIC_RUN;
            default:
               state_reg <= MCUIC_RUN;
         endcase
      end
   end
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         wake_latch_reg <= 1'b0;
      else if (state_reg == MCUIC_SLEEP && ext_hit)
         wake_latch_reg <= 1'b1;
      else if (take)
         wake_latch_reg <= 1'b0;
   end
   assign wake = state_reg == MCUIC_SLEEP && ext_hit;

   assign rd_ok = 1'b1;
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (hsel & hready & htrans[1] & ~hwrite & rd_ok)
      begin
         case (haddr[9:2])
            IDX_EDGE: hrdata <= {24'h000000, 3'h0, edge_reg, 3'h0};
            IDX_FLAGS: hrdata <= {24'h000000, flags_reg};
            IDX_ENABLES: hrdata <= {24'h000000, enables_reg};
            IDX_STACK: hrdata <= {24'h000000, gie_reg, 4'h0, stack_reg};
            IDX_CTX_ACC: hrdata <= {24'h000000, restore_reg.acc};
            IDX_CTX_PFL: hrdata <= {24'h000000, restore_reg.pflags};
            IDX_PC: hrdata <= {16'h0000, pc_reg};
            default: hrdata <= 32'h0000_0000;
         endcase
      end
   end

   a_flag_sticky: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(flags_reg[BIT_T0]) && !$past(sw_clr[BIT_T0]) |-> flags_reg[BIT_T0])
      else $error("flag lost without clear");
   a_set_wins: assert property (@(posedge hclk) disable iff (!hresetn)
      hw_set[BIT_MSP] |=> flags_reg[BIT_MSP])
      else $error("set lost");
   a_take_gie: assert property (@(posedge hclk) disable iff (!hresetn)
      take |-> gie_reg ##1 !gie_reg && pc_reg == IRQ_VECTOR)
      else $error("take without gie or bad vector");
   a_return_from_irq_instr_gie: assert property (@(posedge hclk) disable iff (!hresetn)
      return_from_irq_instr && !take |=> gie_reg && stack_reg == $past(stack_reg) + 3'h1)
      else $error("return_from_irq_instr did not restore gie");
   a_reserved_zero: assert property (@(posedge hclk) disable iff (!hresetn)
      (flags_reg & ~SRC_MASK) == 8'h00 && (enables_reg & ~SRC_MASK) == 8'h00)
      else $error("reserved bit set");
   a_ext_noenable: assert property (@(posedge hclk) disable iff (!hresetn)
      ext_hit |=> flags_reg[BIT_EXT])
      else $error("edge missed");
   a_push_excl: assert property (@(posedge hclk) disable iff (!hresetn)
      ctl_reg[CTL_PUSH] |=> (ctx_reg.pflags & PFL_KEEP_MASK) == 8'h00 && ctx_reg.acc == $past(cpu_acc))
      else $error("push kept status bits");
   a_wake_latch: assert property (@(posedge hclk) disable iff (!hresetn)
      state_reg == MCUIC_SLEEP && ext_hit |=> wake_latch_reg && state_reg == MCUIC_RUN)
      else $error("wake edge not latched");
   c_take: cover property (@(posedge hclk) disable iff (!hresetn) take);
   c_return_from_irq_instr: cover property (@(posedge hclk) disable iff (!hresetn) return_from_irq_instr);
   c_wake: cover property (@(posedge hclk) disable iff (!hresetn) wake);
   c_push: cover property (@(posedge hclk) disable iff (!hresetn) ctl_reg[CTL_PUSH]);
   c_pop: cover property (@(posedge hclk) disable iff (!hresetn) ctl_reg[CTL_POP]);
endmodule : mcuic_top
`default_nettype wire

/* File: dv/mcuic_src_model.sv */
// mcuic_src_model: the five internal request sources beside the controller
// assumes the bench asks for requests with a one-cycle mask at flag positions
`timescale 1ns/1ps
`default_nettype none
module mcuic_src_model
   import mcuic_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [7:0] fire,
   output logic msp_req,
   output logic sio_req,
   output logic t0_ovf,
   output logic tc1_ovf,
   output logic cmp_req
);
   // one-cycle pulses: a held level would set the flag again after a clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         {msp_req, sio_req, t0_ovf, tc1_ovf, cmp_req} <= 5'h00;
      end
      else
      begin
         {msp_req, sio_req, t0_ovf} <= {fire[BIT_MSP], fire[BIT_SIO], fire[BIT_T0]};
         {tc1_ovf, cmp_req} <= {fire[BIT_TC1], fire[BIT_CMP]};
      end
   end
endmodule : mcuic_src_model
`default_nettype wire

/* File: dv/tb.sv */
// tb: self-checking bench for the interrupt controller over ahb-lite
// assumes zero-wait-state registers and cpu instructions as control writes
`timescale 1ns/1ps
`default_nettype none
module tb
   import mcuic_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ext_pin, powerdown;
   logic msp_req, sio_req, t0_ovf, tc1_ovf, cmp_req, irq_take, wake, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] cpu_acc, cpu_pflags, fire, v, a2, p2, p3;
   logic [15:0] pc_load;
   int err_count, n_tests, takes, wakes;
   mcuic_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ext_pin(ext_pin), .msp_req(msp_req), .sio_req(sio_req),
      .t0_ovf(t0_ovf), .tc1_ovf(tc1_ovf), .cmp_req(cmp_req), .powerdown(powerdown), .cpu_acc(cpu_acc),
      .cpu_pflags(cpu_pflags), .irq_take(irq_take), .pc_load(pc_load), .wake(wake), .irq(irq));
   mcuic_src_model src (.hclk(hclk), .hresetn(hresetn), .fire(fire), .msp_req(msp_req),
      .sio_req(sio_req), .t0_ovf(t0_ovf), .tc1_ovf(tc1_ovf), .cmp_req(cmp_req));
   initial
   begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      if (irq_take === 1'b1) takes <= takes + 1;
      if (wake === 1'b1) wakes <= wakes + 1;
   end
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic idle(input int n);
      repeat (n) @(posedge hclk);
   endtask : idle
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         $display("Error at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask : cmp
   // address phase held until hready, then data phase held until hready again
   task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {22'h000000, idx, 2'b00};
      hwrite <= w;
      htrans <= 2'b10;
      hsize <= 3'h2;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, idx, d, r);
   endtask : wr
   task automatic chk(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] r;
      bus(1'b0, idx, 8'h00, r);
      cmp(r, {24'h000000, exp});
   endtask : chk
   // bit 0 is the pin, falling edge in the reset edge mode; others come from the model
   task automatic raise(input int i);
      if (i == 0)
      begin
         ext_pin <= 1'b0;
         idle(3);
         ext_pin <= 1'b1;
      end
      else
      begin
         fire <= 8'h01 << i;
         idle(1);
         fire <= 8'h00;
      end
      idle(3);
   endtask : raise
   initial
   begin
      #200000;
      err_count++;
      tally_and_finish();
   end
   initial
   begin
      {hresetn, hsel, hwrite, powerdown, haddr, hwdata, htrans, hsize} = '0;
      // pin idles high so the reset value of the edge detector sees no false edge
      ext_pin = 1'b1;
      {fire, cpu_acc, cpu_pflags} = 24'h000000;
      err_count = 0;
      n_tests = 0;
      takes = 0;
      wakes = 0;
      void'($urandom(32'h7fb6f92c));
      idle(12);
      hresetn <= 1'b1;
      idle(1);
      chk(IDX_EDGE, {3'h0, EDGE_RESET, 3'h0});
      chk(IDX_STACK, {5'h00, STACK_RESET});
      chk(IDX_ENABLES, 8'h00);
      chk(8'h40, 8'h00);
      cmp({31'h0, hresp}, 32'h0);
      v = 8'($urandom);
      wr(IDX_ENABLES, v);
      chk(IDX_ENABLES, v & SRC_MASK);
      wr(IDX_ENABLES, 8'h00);
      wr(IDX_FLAGS, 8'hff);
      chk(IDX_FLAGS, 8'h00);
      for (int i = 0; i < 8; i++)
      begin
         if (!SRC_MASK[i]) continue;
         raise(i);
         chk(IDX_FLAGS, 8'h01 << i);
         chk(IDX_FLAGS, 8'h01 << i);
         wr(IDX_FLAGS, 8'h00);
      end
      fire <= 8'h50;
      idle(1);
      fire <= 8'h00;
      idle(3);
      wr(IDX_FLAGS, 8'hbf);
      chk(IDX_FLAGS, 8'h10);
      for (int i = 0; i < 4; i++)
      begin
         wr(IDX_EDGE, {3'h0, 2'(i), 3'h0});
         wr(IDX_FLAGS, 8'h00);
         ext_pin <= 1'b0;
         idle(3);
         chk(IDX_FLAGS, {7'h00, i[1]});
         wr(IDX_FLAGS, 8'h00);
         ext_pin <= 1'b1;
         idle(3);
         chk(IDX_FLAGS, {7'h00, i[0]});
      end
      wr(IDX_EDGE, {3'h0, EDGE_FALL, 3'h0});
      wr(IDX_FLAGS, 8'h00);
      v = (8'($urandom) & SRC_MASK) | 8'h10;
      wr(IDX_ENABLES, v);
      raise(BIT_T0);
      wr(IDX_CPU_CTL, 8'h08);
      idle(3);
      cmp(takes, 0);
      wr(IDX_STACK, 8'h87);
      idle(1);
      cmp({31'h0, irq}, 32'h1);
      wr(IDX_ENABLES, v & 8'hef);
      idle(1);
      cmp({31'h0, irq}, 32'h0);
      wr(IDX_ENABLES, v);
      wr(IDX_CPU_CTL, 8'h08);
      idle(3);
      cmp(takes, 1);
      cmp({16'h0, pc_load}, {16'h0, IRQ_VECTOR});
      cmp({31'h0, irq}, 32'h0);
      chk(IDX_STACK, 8'h06);
      cpu_acc <= 8'($urandom);
      cpu_pflags <= 8'($urandom);
      wr(IDX_CPU_CTL, 8'h01);
      // control pulses act one cycle after the write lands: hold cpu inputs over it
      idle(1);
      a2 = 8'($urandom);
      p2 = 8'($urandom);
      p3 = 8'($urandom);
      cpu_acc <= a2;
      cpu_pflags <= p2;
      wr(IDX_CPU_CTL, 8'h01);
      idle(1);
      cpu_pflags <= p3;
      wr(IDX_CPU_CTL, 8'h02);
      idle(1);
      chk(IDX_CTX_ACC, a2);
      chk(IDX_CTX_PFL, (p2 & ~PFL_KEEP_MASK) | (p3 & PFL_KEEP_MASK));
      wr(IDX_FLAGS, 8'h00);
      wr(IDX_CPU_CTL, 8'h04);
      idle(1);
      chk(IDX_STACK, 8'h87);
      wr(IDX_ENABLES, 8'h01);
      powerdown <= 1'b1;
      // the edge must come once the controller is asleep, not in the cycle it enters sleep
      idle(2);
      ext_pin <= 1'b0;
      idle(3);
      cmp({31'h0, wakes != 0}, 32'h1);
      powerdown <= 1'b0;
      ext_pin <= 1'b1;
      wr(IDX_FLAGS, 8'h00);
      chk(IDX_FLAGS, 8'h01);
      wr(IDX_CPU_CTL, 8'h08);
      idle(3);
      cmp(takes, 2);
      wr(IDX_CPU_CTL, 8'h04);
      wr(IDX_FLAGS, 8'h00);
      chk(IDX_FLAGS, 8'h00);
      tally_and_finish();
   end
endmodule : tb
`default_nettype wire
